/* hdl/hrx_consts.svh */
// Constants of the receive HDLC controller: offsets, fields, codes, counts.
// Assumes one 100 MHz clock and a 16-bit register port with byte lanes.
//
// Summary of operation
// - threshold field counts eight-byte groups of stored receive data
// - data-available is high while occupancy is at or above threshold
// - reorder 0 puts first bit in byte LSB, reorder 1 in MSB
// - inversion control complements every incoming bit before framing
// - check-sequence disable clear means the trailing FCS is checked
// - queue reset empties queue, halts, powers RAM down, drops data
// - after queue reset, discard until RAM is up and a frame opens
// - full reads 1 only when queue cannot take another byte
// - empty reads 1 when no byte is stored, else 0
// - byte arriving at a full queue is lost and sets overflow flag
// - writing a packet-end entry sets the packet-end flag
// - writing a packet-start entry sets the packet-start flag
// - full flag is set on the rising edge of live full only
// - available flag is set on the rising edge of live available only
// - interrupt needs flag set, its enable, and the port global enable
// - only an upper-byte data read advances the queue and output
// - lower-byte data read shows status of the next upper byte
// - data-valid bit is 1 for a valid byte, 0 when queue empty
// - first bit in LSB without reordering, MSB with reordering
`ifndef HRX_CONSTS_SVH
`define HRX_CONSTS_SVH

`define HRX_OFS_CTRL   8'hb0
`define HRX_OFS_STAT   8'hb4
`define HRX_OFS_LAT    8'hb6
`define HRX_OFS_IE     8'hb8
`define HRX_OFS_FIFO   8'hbc

`define HRX_THR_HI     12
`define HRX_THR_LO     8
`define HRX_CTL_LO     3
`define HRX_CTRL_RST   9'h080

`define HRX_ST_FULL    2
`define HRX_ST_EMPTY   1
`define HRX_ST_AVAIL   0

`define HRX_B_OVF      7
`define HRX_B_PE       4
`define HRX_B_PS       3
`define HRX_B_FULL     2
`define HRX_B_AVL      0
`define HRX_LAT_MASK   8'h9d

`define HRX_CODE_MID   3'h0
`define HRX_CODE_START 3'h1
`define HRX_CODE_GOOD  3'h4
`define HRX_CODE_FCS   3'h5
`define HRX_CODE_INVAL 3'h6
`define HRX_CODE_ABORT 3'h7
`define HRX_CODE_END   2

`define HRX_DEPTH      9'h100
`define HRX_FLAG       8'h7e
`define HRX_ABORT7     7'h7f
`define HRX_STUFF7     7'h3e
`define HRX_SR_FULL    4'h8
`define HRX_LAST_BIT   3'h7
`define HRX_GRP_PAD    3'h0
`define HRX_HOLD_FCS   2'h3
`define HRX_HOLD_RAW   2'h1
`define HRX_CRC_INIT   16'hffff
`define HRX_CRC_GOOD   16'hf0b8
`define HRX_CRC_POLY   16'h8408
// ram wake-up delay; value arbitrary
`define HRX_PWRUP_CYC  5'h10

`endif

/* hdl/hrx_pkg.sv */
// Types shared by the receive HDLC controller.
// Assumes the constants header is included by the design file.
package hrx_pkg;
  typedef struct packed {
    logic [2:0] code;
    logic [7:0] data;
  } hrx_entry_t;

  typedef struct packed {
    logic [4:0] avail_threshold_groups;
    logic       bit_order_reverse;
    logic       input_invert;
    logic       check_sequence_disable;
    logic       queue_reset;
  } hrx_ctrl_t;

  typedef enum logic [1:0] {
    rx_discard,
    rx_hunt,
    rx_frame
  } hrx_state_t;
endpackage

/* hdl/hrx_receive_controller.sv */
// Receive HDLC controller: deframer, FCS check, 256-byte queue, registers.
// Assumes the serial bit and its enable come from logic on the same clock.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "hrx_consts.svh"
module hrx_receive_controller (
  input  wire logic        clock,              // system clock
  input  wire logic        sys_rst,            // sync reset, high
  input  wire logic        link_bit,           // serial data bit
  input  wire logic        link_bit_en,        // bit qualifier
  input  wire logic        port_global_irq_en, // port global enable
  input  wire logic [7:0]  bus_addr,           // register byte address
  input  wire logic [15:0] bus_wdata,          // write data
  input  wire logic [1:0]  bus_byte_en,        // lane enables
  input  wire logic        bus_wr,             // write strobe
  input  wire logic        bus_rd,             // read strobe
  output logic      [15:0] bus_rdata,          // read data, next cycle
  output logic             irq_req,            // interrupt request
  output logic             ram_power_en        // queue ram powered
);

  // ----------------------------------------
  // registers and bus decode
  // ----------------------------------------
  hrx_pkg::hrx_ctrl_t  ctrl;
  logic [7:0]          irq_en;
  logic [7:0]          lat;
  logic [7:0]          set_vec;
  logic                avail_lvl;
  logic                full;
  logic                empty;
  logic                pop;
  hrx_pkg::hrx_entry_t out_q;
  logic                out_valid;

  wire wr_lo = bus_wr && bus_byte_en[0];
  wire wr_hi = bus_wr && bus_byte_en[1];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= `HRX_CTRL_RST;
    end else if (bus_addr == `HRX_OFS_CTRL) begin
      if (wr_hi) begin
        ctrl.avail_threshold_groups <= bus_wdata[`HRX_THR_HI:`HRX_THR_LO];
      end
      if (wr_lo) begin
        ctrl[`HRX_CTL_LO:0] <= bus_wdata[`HRX_CTL_LO:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_en <= 8'h00;
    end else if (wr_lo && bus_addr == `HRX_OFS_IE) begin
      irq_en <= bus_wdata[7:0] & `HRX_LAT_MASK;
    end
  end

  // upper lane read is what consumes a byte; guarded by valid
  assign pop = bus_rd && bus_byte_en[1] && out_valid &&
               bus_addr == `HRX_OFS_FIFO;

  always_ff @(posedge clock) begin
    if (sys_rst || !bus_rd) begin
      bus_rdata <= 16'h0000;
    end else begin
      unique case (bus_addr)
        `HRX_OFS_CTRL: begin
          bus_rdata <= {3'h0, ctrl.avail_threshold_groups,
                        4'h0, ctrl[`HRX_CTL_LO:0]};
        end
        `HRX_OFS_STAT: begin
          bus_rdata <= {13'h0000, full, empty, avail_lvl};
        end
        `HRX_OFS_LAT: begin
          bus_rdata <= {8'h00, lat};
        end
        `HRX_OFS_IE: begin
          bus_rdata <= {8'h00, irq_en};
        end
        `HRX_OFS_FIFO: begin
          // low lane shows code and valid of the byte the next upper read takes
          bus_rdata <= {out_q.data, 4'h0, out_q.code,
                        out_valid};
        end
        default: begin
          bus_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // queue reset and ram power
  // ----------------------------------------
  logic [4:0] pwr_cnt;
  wire        pwr_done = pwr_cnt == `HRX_PWRUP_CYC;

  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      pwr_cnt <= 5'h00;
    end else if (!pwr_done) begin
      pwr_cnt <= pwr_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ram_power_en <= 1'b0;
    end else begin
      ram_power_en <= !ctrl.queue_reset;
    end
  end

  // ----------------------------------------
  // bit front end: invert, flag, abort, destuff
  // ----------------------------------------
  hrx_pkg::hrx_state_t st;
  logic [7:0]          sr;
  logic [7:0]          drop;
  logic [3:0]          fill;

  wire       in_bit   = link_bit ^ ctrl.input_invert;
  wire [7:0] win      = {sr[6:0], in_bit};
  wire       is_flag  = link_bit_en && win == `HRX_FLAG;
  wire       is_abort = link_bit_en && win[6:0] == `HRX_ABORT7;
  wire       stuffed  = win[6:0] == `HRX_STUFF7;
  // bits leave eight late so a flag is never taken as data
  wire       dbit_v   = link_bit_en && fill == `HRX_SR_FULL &&
                        !drop[7] && st == hrx_pkg::rx_frame;
  wire       dbit     = sr[7];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sr   <= 8'h00;
      drop <= 8'h00;
      fill <= 4'h0;
    end else if (link_bit_en) begin
      sr <= win;
      if (is_flag || is_abort) begin
        drop <= 8'h00;
        fill <= 4'h0;
      end else begin
        drop <= {drop[6:0], stuffed};
        if (fill != `HRX_SR_FULL) begin
          fill <= fill + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      st <= hrx_pkg::rx_discard;
    end else begin
      unique case (st)
        hrx_pkg::rx_discard: begin
          if (pwr_done && is_flag) begin
            st <= hrx_pkg::rx_frame;
          end
        end
        hrx_pkg::rx_hunt: begin
          if (is_flag) begin
            st <= hrx_pkg::rx_frame;
          end
        end
        hrx_pkg::rx_frame: begin
          if (is_abort) begin
            st <= hrx_pkg::rx_hunt;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // byte assembly and fcs
  // ----------------------------------------
  logic [7:0]  acc;
  logic [2:0]  nbit;
  logic [15:0] crc;
  logic        close_q;
  logic        abort_q;

  wire [7:0] next_acc = ctrl.bit_order_reverse ?
                        {acc[6:0], dbit} :
                        {dbit, acc[7:1]};
  wire       byte_done = dbit_v && nbit == `HRX_LAST_BIT;
  wire [15:0] next_crc = {1'b0, crc[15:1]} ^
                         ((crc[0] ^ dbit) ? `HRX_CRC_POLY : 16'h0000);

  // closing is one cycle late so a byte ending at the flag is kept
  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      close_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      close_q <= st == hrx_pkg::rx_frame && (is_flag || is_abort);
      abort_q <= st == hrx_pkg::rx_frame && is_abort;
    end
  end

  // held clear outside a frame so a cut frame leaves no stale bits
  always_ff @(posedge clock) begin
    if (sys_rst || close_q || st != hrx_pkg::rx_frame) begin
      acc  <= 8'h00;
      nbit <= 3'h0;
      crc  <= `HRX_CRC_INIT;
    end else if (dbit_v) begin
      acc  <= next_acc;
      nbit <= nbit + 3'h1;
      crc  <= next_crc;
    end
  end

  // ----------------------------------------
  // hold-back of fcs bytes and entry tagging
  // ----------------------------------------
  logic [7:0]          h0;
  logic [7:0]          h1;
  logic [7:0]          h2;
  logic [1:0]          hcnt;
  logic                first;
  logic                emit;
  hrx_pkg::hrx_entry_t emit_entry;
  logic [2:0]          end_code;

  // the last two bytes are the fcs unless checking is off
  wire [1:0] hmax = ctrl.check_sequence_disable ?
                    `HRX_HOLD_RAW : `HRX_HOLD_FCS;
  wire       hfull = hcnt == hmax;
  wire [7:0] pend  = ctrl.check_sequence_disable ? h0 : h2;

  always_comb begin
    if (abort_q) begin
      end_code = `HRX_CODE_ABORT;
    end else if (nbit != 3'h0) begin
      end_code = `HRX_CODE_INVAL;
    end else if (!ctrl.check_sequence_disable &&
                 crc != `HRX_CRC_GOOD) begin
      end_code = `HRX_CODE_FCS;
    end else begin
      end_code = `HRX_CODE_GOOD;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      h0         <= 8'h00;
      h1         <= 8'h00;
      h2         <= 8'h00;
      hcnt       <= 2'h0;
      first      <= 1'b1;
      emit       <= 1'b0;
      emit_entry <= '0;
    end else if (close_q) begin
      emit       <= hfull;
      emit_entry <= {end_code, pend};
      hcnt       <= 2'h0;
      first      <= 1'b1;
    end else if (byte_done) begin
      emit       <= hfull;
      emit_entry <= {first ? `HRX_CODE_START : `HRX_CODE_MID, pend};
      if (hfull) begin
        first <= 1'b0;
      end else begin
        hcnt <= hcnt + 2'h1;
      end
      h0 <= next_acc;
      h1 <= h0;
      h2 <= h1;
    end else begin
      emit <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive queue
  // ----------------------------------------
  hrx_pkg::hrx_entry_t mem [0:255];
  logic [7:0]          wr_ptr;
  logic [7:0]          rd_ptr;
  logic [8:0]          count;

  assign full  = count == `HRX_DEPTH;
  assign empty = count == 9'h000;
  wire wr_en   = emit && !full && !ctrl.queue_reset;
  wire ovf_evt = emit && full && !ctrl.queue_reset;
  wire [8:0] left    = count - {8'h00, pop};
  wire [7:0] rd_next = rd_ptr + {7'h00, pop};

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_ptr] <= emit_entry;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      wr_ptr <= 8'h00;
      rd_ptr <= 8'h00;
      count  <= 9'h000;
    end else begin
      wr_ptr <= wr_ptr + {7'h00, wr_en};
      rd_ptr <= rd_next;
      count  <= left + {8'h00, wr_en};
    end
  end

  // output stage changes only when consumed, when it was empty, or on reset or queue reset
  always_ff @(posedge clock) begin
    if (sys_rst || ctrl.queue_reset) begin
      out_q     <= '0;
      out_valid <= 1'b0;
    end else if (pop || !out_valid) begin
      if (left != 9'h000) begin
        out_q <= mem[rd_next];
      end else if (wr_en) begin
        out_q <= emit_entry;
      end
      out_valid <= left != 9'h000 || wr_en;
    end
  end

  // ----------------------------------------
  // status, latched flags, interrupt
  // ----------------------------------------
  logic full_q;
  logic avail_q;

  assign avail_lvl = !ctrl.queue_reset && count >=
                     {1'b0, ctrl.avail_threshold_groups, `HRX_GRP_PAD};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      full_q  <= 1'b0;
      avail_q <= 1'b0;
    end else begin
      full_q  <= full;
      avail_q <= avail_lvl;
    end
  end

  always_comb begin
    set_vec = 8'h00;
    set_vec[`HRX_B_OVF]  = ovf_evt;
    set_vec[`HRX_B_PE]   = wr_en && emit_entry.code[`HRX_CODE_END];
    set_vec[`HRX_B_PS]   = wr_en &&
                           emit_entry.code == `HRX_CODE_START;
    set_vec[`HRX_B_FULL] = full && !full_q;
    set_vec[`HRX_B_AVL]  = avail_lvl && !avail_q;
  end

  // a set in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lat <= 8'h00;
    end else if (wr_lo && bus_addr == `HRX_OFS_LAT) begin
      lat <= (lat & ~bus_wdata[7:0]) | set_vec;
    end else begin
      lat <= lat | set_vec;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= port_global_irq_en && |(lat & irq_en);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_full_rise;
    @(posedge clock) disable iff (sys_rst)
      $rose(full) |=> lat[`HRX_B_FULL];
  endproperty
  a_full_rise: assert property (p_full_rise)
    else $error("full flag not set on full rise");

  property p_ovf;
    @(posedge clock) disable iff (sys_rst)
      (emit && full && !ctrl.queue_reset) |=>
        lat[`HRX_B_OVF] && $stable(count);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged or data stored");

  property p_hold_out;
    @(posedge clock) disable iff (sys_rst)
      (out_valid && !pop && !ctrl.queue_reset) |=>
        out_valid && $stable(out_q);
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("output byte changed without upper read");

  property p_qreset;
    @(posedge clock) disable iff (sys_rst)
      ctrl.queue_reset |=> count == 9'h000 && !avail_lvl && !out_valid;
  endproperty
  a_qreset: assert property (p_qreset)
    else $error("queue not cleared under reset control");

  property p_resync;
    @(posedge clock) disable iff (sys_rst)
      $fell(ctrl.queue_reset) |-> (st == hrx_pkg::rx_discard)[*8];
  endproperty
  a_resync: assert property (p_resync)
    else $error("storage resumed before ram power-up");

  property p_empty_read;
    @(posedge clock) disable iff (sys_rst)
      (bus_rd && bus_addr == `HRX_OFS_STAT) |=>
        bus_rdata[`HRX_ST_EMPTY] == $past(count == 9'h000);
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty bit does not match occupancy");

  property p_irq;
    @(posedge clock) disable iff (sys_rst)
      irq_req |-> $past(port_global_irq_en) && $past(|(lat & irq_en));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled flag");

  property p_lsb_first;
    @(posedge clock) disable iff (sys_rst)
      (dbit_v && !ctrl.bit_order_reverse && !close_q) |=>
        acc[7] == $past(dbit);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("received bit not shifted in from the top");

  property p_start_flag;
    @(posedge clock) disable iff (sys_rst)
      (wr_en && emit_entry.code == `HRX_CODE_START) |=>
        lat[`HRX_B_PS] ##1 lat[`HRX_B_PS] || $past(wr_lo);
  endproperty
  a_start_flag: assert property (p_start_flag)
    else $error("packet start flag not set");

  property p_end_flag;
    @(posedge clock) disable iff (sys_rst)
      (wr_en && emit_entry.code[`HRX_CODE_END]) |=> lat[`HRX_B_PE];
  endproperty
  a_end_flag: assert property (p_end_flag)
    else $error("packet end flag not set");

endmodule

/* test/hrx_link_src.sv */
// Far-side model: serial data-link source feeding the receive controller.
// Assumes one shared clock; one line bit per cycle while a frame is sent.
`timescale 1ns/100ps
`include "hrx_consts.svh"
module hrx_link_src (
  input  wire logic clock,      // system clock
  input  wire logic invert_en,  // send complemented line bits
  output logic      link_bit,   // serial bit to receiver
  output logic      link_bit_en // bit qualifier
);
  logic [7:0]  frame_q[$];
  logic [15:0] crc;
  logic [15:0] fcs;
  logic [7:0]  flag_v;
  logic        active;
  int          ones;

  initial begin
    link_bit = 1'b0;
    link_bit_en = 1'b0;
    active = 1'b0;
    flag_v = `HRX_FLAG;
  end

  // ----------------------------------------------------------------
  // idle line
  // ----------------------------------------------------------------
  // toggles so a stale level never looks like a held bit
  always @(posedge clock) begin
    if (!active) begin
      link_bit_en <= 1'b0;
      link_bit    <= ~link_bit;
    end
  end

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  task put(input logic b);
    @(posedge clock);
    link_bit    <= b ^ invert_en;
    link_bit_en <= 1'b1;
  endtask

  // zero inserted after five ones so data never mimics a flag
  task dbit(input logic b);
    put(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      put(1'b0);
      ones = 0;
    end
  endtask

  task flag();
    for (int i = 0; i < 8; i++) put(flag_v[i]);
    ones = 0;
  endtask

  // bytes leave lsb first; bad flips one fcs bit
  task send(input logic fcs_on, input logic bad, input logic abort);
    active = 1'b1;
    ones = 0;
    crc = `HRX_CRC_INIT;
    flag();
    foreach (frame_q[k]) begin
      for (int i = 0; i < 8; i++) begin
        dbit(frame_q[k][i]);
        crc = (crc >> 1) ^ ((crc[0] ^ frame_q[k][i]) ? `HRX_CRC_POLY : 16'h0);
      end
    end
    if (abort) begin
      repeat (8) put(1'b1);
    end else begin
      fcs = ~crc ^ {15'h0, bad};
      if (fcs_on) begin
        for (int i = 0; i < 16; i++) dbit(fcs[i]);
      end
      flag();
    end
    frame_q.delete();
    @(negedge clock);
    active = 1'b0;
  endtask
endmodule

/* test/test_hdlc_receive_controller.sv */
// Self-checking bench of the receive HDLC controller.
// Assumes the link source model and the register port of the design.
`timescale 1ns/100ps
`include "hrx_consts.svh"
module test_hdlc_receive_controller;
  logic        clock;
  logic        sys_rst;
  logic        link_bit;
  logic        link_bit_en;
  logic        port_global_irq_en;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic [1:0]  bus_byte_en;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic        irq_req;
  logic        ram_power_en;
  logic        invert_en;
  logic [15:0] v;
  int          error_cnt;
  int          checked;

  hrx_receive_controller dut_u (
    .clock(clock), .sys_rst(sys_rst), .link_bit(link_bit),
    .link_bit_en(link_bit_en), .port_global_irq_en(port_global_irq_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .irq_req(irq_req), .ram_power_en(ram_power_en));

  hrx_link_src link_u (
    .clock(clock), .invert_en(invert_en), .link_bit(link_bit),
    .link_bit_en(link_bit_en));

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_byte_en <= 2'b11;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [1:0] be);
    @(posedge clock);
    bus_addr <= a;
    bus_byte_en <= be;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    rd(a, 2'b11);
    chk(n, e, v);
  endtask

  task pop(input logic [7:0] b, input logic [2:0] c);
    rchk("queue entry", `HRX_OFS_FIFO, {b, 4'h0, c, 1'b1});
  endtask

  task frame(input int n, input logic [7:0] b0, input logic fcs_on,
             input logic bad, input logic abort);
    for (int k = 0; k < n; k++) link_u.frame_q.push_back(b0 + k[7:0]);
    link_u.send(fcs_on, bad, abort);
    repeat (6) @(posedge clock);
  endtask

  task print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rchk("control", `HRX_OFS_CTRL, 16'h0800);
    rchk("irq enable", `HRX_OFS_IE, 16'h0000);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    rchk("latched", `HRX_OFS_LAT, 16'h0000);
    rchk("unmapped", 8'hb2, 16'h0000);
    wr(`HRX_OFS_STAT, 16'hffff);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    rd(`HRX_OFS_FIFO, 2'b01);
    chk("queue_byte_valid", 16'h0, {15'h0, v[0]});
    chk("ram_power_en", 16'h1, {15'h0, ram_power_en});
    repeat (20) @(posedge clock);
  endtask

  task t_good();
    frame(3, 8'h31, 1'b1, 1'b0, 1'b0);
    rd(`HRX_OFS_FIFO, 2'b01);
    chk("lower lane", 16'h0003, {8'h0, v[7:0]});
    rchk("latched", `HRX_OFS_LAT, 16'h0018);
    pop(8'h31, `HRX_CODE_START);
    pop(8'h32, `HRX_CODE_MID);
    pop(8'h33, `HRX_CODE_GOOD);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    wr(`HRX_OFS_LAT, 16'h009d);
    rchk("latched", `HRX_OFS_LAT, 16'h0000);
  endtask

  task t_codes();
    frame(2, 8'h55, 1'b1, 1'b1, 1'b0);
    pop(8'h55, `HRX_CODE_START);
    pop(8'h56, `HRX_CODE_FCS);
    wr(`HRX_OFS_CTRL, 16'h0802);
    frame(3, 8'h40, 1'b0, 1'b0, 1'b0);
    pop(8'h40, `HRX_CODE_START);
    pop(8'h41, `HRX_CODE_MID);
    pop(8'h42, `HRX_CODE_GOOD);
    // the abort cuts the fourth byte, so three entries are stored
    frame(4, 8'h50, 1'b0, 1'b0, 1'b1);
    pop(8'h50, `HRX_CODE_START);
    pop(8'h51, `HRX_CODE_MID);
    pop(8'h52, `HRX_CODE_ABORT);
  endtask

  // reversed order plus line inversion undone by the receiver
  task t_order();
    wr(`HRX_OFS_CTRL, 16'h080e);
    invert_en = 1'b1;
    frame(1, 8'h01, 1'b0, 1'b0, 1'b0);
    invert_en = 1'b0;
    pop(8'h80, `HRX_CODE_GOOD);
  endtask

  task t_fill();
    wr(`HRX_OFS_CTRL, 16'h0102);
    wr(`HRX_OFS_IE, 16'h009d);
    port_global_irq_en <= 1'b1;
    frame(8, 8'h00, 1'b0, 1'b0, 1'b0);
    rchk("status", `HRX_OFS_STAT, 16'h0001);
    rchk("latched", `HRX_OFS_LAT, 16'h0019);
    chk("irq_req", 16'h1, {15'h0, irq_req});
    pop(8'h00, `HRX_CODE_START);
    rchk("status", `HRX_OFS_STAT, 16'h0000);
    wr(`HRX_OFS_LAT, 16'h009d);
    rchk("latched", `HRX_OFS_LAT, 16'h0000);
    chk("irq_req", 16'h0, {15'h0, irq_req});
    frame(260, 8'h00, 1'b0, 1'b0, 1'b0);
    rchk("status", `HRX_OFS_STAT, 16'h0005);
    rchk("latched", `HRX_OFS_LAT, 16'h008d);
    @(posedge clock);
    port_global_irq_en <= 1'b0;
    repeat (3) @(posedge clock);
    chk("irq_req", 16'h0, {15'h0, irq_req});
    port_global_irq_en <= 1'b1;
    repeat (3) @(posedge clock);
    chk("irq_req", 16'h1, {15'h0, irq_req});
    wr(`HRX_OFS_LAT, 16'h009d);
    rchk("latched", `HRX_OFS_LAT, 16'h0000);
    chk("irq_req", 16'h0, {15'h0, irq_req});
    pop(8'h01, `HRX_CODE_MID);
    rchk("status", `HRX_OFS_STAT, 16'h0001);
  endtask

  task t_qreset();
    wr(`HRX_OFS_CTRL, 16'h0103);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    chk("ram_power_en", 16'h0, {15'h0, ram_power_en});
    frame(2, 8'h20, 1'b0, 1'b0, 1'b0);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    wr(`HRX_OFS_CTRL, 16'h0102);
    frame(2, 8'h60, 1'b0, 1'b0, 1'b0);
    rchk("status", `HRX_OFS_STAT, 16'h0002);
    chk("ram_power_en", 16'h1, {15'h0, ram_power_en});
    frame(1, 8'h70, 1'b0, 1'b0, 1'b0);
    pop(8'h70, `HRX_CODE_GOOD);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    port_global_irq_en = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_byte_en = 2'b00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    invert_en = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_good();
    t_codes();
    t_order();
    t_fill();
    t_qreset();
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
endmodule
